// ==== pinmux_pkg.sv ====
// package: register map, field layout and function codes for the pin mux
package pinmux_pkg;
  // register word indices (printed offsets are not multiples of four: byte address is index * 4)
  localparam logic [11:0] THRESHOLD_SEL_A_IDX = 12'h1F5;
  localparam logic [11:0] THRESHOLD_SEL_B_IDX = 12'h1F6;
  localparam logic [11:0] THRESHOLD_SEL_C_IDX = 12'h1F7;
  localparam logic [11:0] PORT_DIR_IDX = 12'h100;
  localparam logic [11:0] SEG_EN_IDX = 12'h101;
  localparam logic [11:0] PULLUP_IDX = 12'h102;
  localparam logic [11:0] ANALOG_SEL_IDX = 12'h103;
  localparam logic [11:0] KEY_IRQ_IDX = 12'h104;
  localparam logic [11:0] STATUS_IDX = 12'h105;
  localparam int ADDR_W = 14;
  localparam logic [7:0] THRESHOLD_RESET = 8'h00;
  localparam logic [31:0] WORD_RESET = 32'h00000000;
  localparam logic [7:0] ANALOG_SEL_RESET = 8'h00;
  // analog select field layout
  localparam int CHAN_LSB = 0;
  localparam int GROUP_LSB = 3;
  localparam logic [1:0] GROUP_P0_LOW = 2'h0;
  localparam logic [1:0] GROUP_HIGH = 2'h1;
  localparam logic [2:0] CHAN_UPPER_BASE = 3'h4;
  localparam logic [2:0] CHAN_LOWER_BASE = 3'h0;
  // threshold codes
  localparam logic [1:0] THR_HALF = 2'h0;
  localparam logic [1:0] THR_LOW = 2'h1;
  localparam logic [1:0] THR_HIGH = 2'h2;
  localparam logic [1:0] THR_BAD = 2'h3;
  // per-pin function codes
  typedef enum logic [2:0] {
    FN_INPUT,
    FN_OUTPUT,
    FN_SEGMENT,
    FN_ANALOG,
    FN_KEY,
    FN_IRQ
  } pin_fn_type;
endpackage

// ==== pinmux_apb_slave.sv ====
// apb slave: two-phase access, answers in the access cycle, flags unmapped addresses
`timescale 1ns/1ps
module pinmux_apb_slave (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  output logic pready,
  output logic pslverr_hit,
  // decoded access
  output logic wr_stb,
  output logic [11:0] reg_idx,
  input wire logic idx_mapped
);
  assign reg_idx = paddr[13:2];
  assign pready = 1'b1;
  assign pslverr_hit = psel && penable && !idx_mapped;
  // write strobe only in the access phase, so one write per transfer
  always_comb begin
    wr_stb = ce && psel && penable && pwrite && idx_mapped && !reset;
  end
endmodule // pinmux_apb_slave

// ==== pin_function_decode.sv ====
// per-pin function decode for ports 0 to 3
`timescale 1ns/1ps
module pin_function_decode (
  // controls for one pin
  input wire logic dir,
  input wire logic seg_en,
  input wire logic analog_hit,
  input wire logic periph_hit,
  input wire pinmux_pkg::pin_fn_type periph_fn,
  // decoded function
  output pinmux_pkg::pin_fn_type fn,
  output logic drive_en
);
  // segment beats everything, then an output direction, then an analog select, then a claimed peripheral input, then input
  always_comb begin
    if (seg_en) begin
      fn = pinmux_pkg::FN_SEGMENT;
    end else if (!dir && analog_hit) begin
      fn = pinmux_pkg::FN_ANALOG;
    end else if (!dir && periph_hit) begin
      fn = periph_fn;
    end else if (dir) begin
      fn = pinmux_pkg::FN_OUTPUT;
    end else begin
      fn = pinmux_pkg::FN_INPUT;
    end
    drive_en = (fn == pinmux_pkg::FN_OUTPUT);
  end
endmodule // pin_function_decode

// ==== port_function_select_and_threshold.sv ====
// top: pin function select for ports 0 to 3 and input threshold registers
`timescale 1ns/1ps
module port_function_select_and_threshold (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [13:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // pin side, ports 0..3 as 32 pins
  output logic [31:0] PIN_OE,
  output logic [31:0] PIN_SEG_SEL,
  output logic [31:0] PIN_PULLUP,
  output logic [31:0] PIN_ANALOG_SEL,
  output logic [7:0] KEY_INPUT_EN,
  output logic [7:0] IRQ_INPUT_EN,
  // threshold selects to the pad ring
  output logic [7:0] THRESHOLD_SEL_A,
  output logic [7:0] THRESHOLD_SEL_B,
  output logic [7:0] THRESHOLD_SEL_C
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] thr_a_r;
  logic [7:0] thr_b_r;
  logic [7:0] thr_c_r;
  logic [31:0] dir_r;
  logic [31:0] seg_r;
  logic [31:0] pullup_r;
  logic [7:0] analog_sel_r;
  logic [31:0] key_irq_r;
  logic wr_stb;
  logic [11:0] reg_idx;
  logic idx_mapped;
  logic pready_c;
  logic slverr_c;
  logic [31:0] rd_nxt;
  logic [31:0] oe_nxt;
  logic [31:0] seg_nxt;
  logic [31:0] pu_nxt;
  logic [31:0] an_nxt;
  logic [7:0] key_nxt;
  logic [7:0] irq_nxt;
  pinmux_pkg::pin_fn_type fn [32];

  function automatic logic is_mapped(input logic [11:0] idx);
    is_mapped = (idx == pinmux_pkg::THRESHOLD_SEL_A_IDX) ||
                (idx == pinmux_pkg::THRESHOLD_SEL_B_IDX) ||
                (idx == pinmux_pkg::THRESHOLD_SEL_C_IDX) ||
                (idx == pinmux_pkg::PORT_DIR_IDX) ||
                (idx == pinmux_pkg::SEG_EN_IDX) ||
                (idx == pinmux_pkg::PULLUP_IDX) ||
                (idx == pinmux_pkg::ANALOG_SEL_IDX) ||
                (idx == pinmux_pkg::KEY_IRQ_IDX) ||
                (idx == pinmux_pkg::STATUS_IDX);
  endfunction

  // writing code 11 keeps the old field: a forbidden level never reaches the pads
  function automatic logic [7:0] thr_merge(input logic [7:0] old, input logic [7:0] nw);
    logic [7:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (nw[2*k +: 2] != pinmux_pkg::THR_BAD) begin
        r[2*k +: 2] = nw[2*k +: 2];
      end
    end
    thr_merge = r;
  endfunction

  assign idx_mapped = is_mapped(reg_idx);

  pinmux_apb_slave u_apb (
    .clk(CLK),
    .reset(RESET),
    .ce(CE),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pready(pready_c),
    .pslverr_hit(slverr_c),
    .wr_stb(wr_stb),
    .reg_idx(reg_idx),
    .idx_mapped(idx_mapped)
  );

  // ----------------------------------------
  // threshold registers
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      thr_a_r <= pinmux_pkg::THRESHOLD_RESET;
      thr_b_r <= pinmux_pkg::THRESHOLD_RESET;
      thr_c_r <= pinmux_pkg::THRESHOLD_RESET;
    end else if (wr_stb) begin
      if (reg_idx == pinmux_pkg::THRESHOLD_SEL_A_IDX) begin
        thr_a_r <= thr_merge(thr_a_r, PWDATA[7:0]);
      end
      if (reg_idx == pinmux_pkg::THRESHOLD_SEL_B_IDX) begin
        thr_b_r <= thr_merge(thr_b_r, PWDATA[7:0]);
      end
      if (reg_idx == pinmux_pkg::THRESHOLD_SEL_C_IDX) begin
        thr_c_r <= thr_merge(thr_c_r, PWDATA[7:0]);
      end
    end
  end

  // ----------------------------------------
  // pin control registers
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      dir_r <= pinmux_pkg::WORD_RESET;
      seg_r <= pinmux_pkg::WORD_RESET;
      pullup_r <= pinmux_pkg::WORD_RESET;
      analog_sel_r <= pinmux_pkg::ANALOG_SEL_RESET;
      key_irq_r <= pinmux_pkg::WORD_RESET;
    end else if (wr_stb) begin
      if (reg_idx == pinmux_pkg::PORT_DIR_IDX) begin
        dir_r <= PWDATA;
      end
      if (reg_idx == pinmux_pkg::SEG_EN_IDX) begin
        seg_r <= PWDATA;
      end
      if (reg_idx == pinmux_pkg::PULLUP_IDX) begin
        pullup_r <= PWDATA;
      end
      if (reg_idx == pinmux_pkg::ANALOG_SEL_IDX) begin
        analog_sel_r <= PWDATA[7:0];
      end
      if (reg_idx == pinmux_pkg::KEY_IRQ_IDX) begin
        key_irq_r <= PWDATA;
      end
    end
  end

  // ----------------------------------------
  // function decode
  // ----------------------------------------
  // key_irq_r: [7:0] key alt select, [15:8] key enable, [23:16] irq alt, [31:24] irq enable
  // enable low/high halves are one byte each in this map
  logic [2:0] chan;
  logic [1:0] grp;
  assign chan = analog_sel_r[pinmux_pkg::CHAN_LSB +: 3];
  assign grp = analog_sel_r[pinmux_pkg::GROUP_LSB +: 2];

  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_pin
      logic an_hit;
      logic per_hit;
      pinmux_pkg::pin_fn_type per_fn;
      logic drv;
      if (g < 4) begin : g_p0lo
        assign an_hit = (grp == pinmux_pkg::GROUP_P0_LOW) &&
                        (chan == pinmux_pkg::CHAN_UPPER_BASE + 3'(g));
      end else if (g < 8) begin : g_p0hi
        assign an_hit = (grp == pinmux_pkg::GROUP_HIGH) &&
                        (chan == pinmux_pkg::CHAN_LOWER_BASE + 3'(g - 4));
      end else if (g < 12) begin : g_p1lo
        assign an_hit = (grp == pinmux_pkg::GROUP_HIGH) &&
                        (chan == pinmux_pkg::CHAN_UPPER_BASE + 3'(g - 8));
      end else begin : g_noan
        assign an_hit = 1'b0;
      end
      if (g >= 16 && g < 24) begin : g_key
        assign per_hit = !key_irq_r[g - 16] && key_irq_r[g - 8];
        assign per_fn = pinmux_pkg::FN_KEY;
      end else if (g >= 24) begin : g_irq
        assign per_hit = !key_irq_r[g - 8] && key_irq_r[g];
        assign per_fn = pinmux_pkg::FN_IRQ;
      end else begin : g_noper
        assign per_hit = 1'b0;
        assign per_fn = pinmux_pkg::FN_INPUT;
      end
      pin_function_decode u_dec (
        .dir(dir_r[g]),
        .seg_en(seg_r[g]),
        .analog_hit(an_hit),
        .periph_hit(per_hit),
        .periph_fn(per_fn),
        .fn(fn[g]),
        .drive_en(drv)
      );
      always_comb begin
        oe_nxt[g] = drv;
        seg_nxt[g] = (fn[g] == pinmux_pkg::FN_SEGMENT);
        an_nxt[g] = (fn[g] == pinmux_pkg::FN_ANALOG);
        pu_nxt[g] = pullup_r[g] && !dir_r[g] && !seg_r[g];
      end
    end
  endgenerate

  always_comb begin
    for (int k = 0; k < 8; k++) begin
      key_nxt[k] = (fn[16 + k] == pinmux_pkg::FN_KEY);
      irq_nxt[k] = (fn[24 + k] == pinmux_pkg::FN_IRQ);
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rd_nxt = 32'h00000000;
    case (reg_idx)
      pinmux_pkg::THRESHOLD_SEL_A_IDX: rd_nxt = {24'h000000, thr_a_r};
      pinmux_pkg::THRESHOLD_SEL_B_IDX: rd_nxt = {24'h000000, thr_b_r};
      pinmux_pkg::THRESHOLD_SEL_C_IDX: rd_nxt = {24'h000000, thr_c_r};
      pinmux_pkg::PORT_DIR_IDX: rd_nxt = dir_r;
      pinmux_pkg::SEG_EN_IDX: rd_nxt = seg_r;
      pinmux_pkg::PULLUP_IDX: rd_nxt = pullup_r;
      pinmux_pkg::ANALOG_SEL_IDX: rd_nxt = {24'h000000, analog_sel_r};
      pinmux_pkg::KEY_IRQ_IDX: rd_nxt = key_irq_r;
      pinmux_pkg::STATUS_IDX: rd_nxt = {8'h00, irq_nxt, key_nxt, 8'h00};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  // read data registered in setup, valid through the access cycle
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PRDATA <= rd_nxt;
      PREADY <= PSEL && !PENABLE && pready_c;
      PSLVERR <= PSEL && !PENABLE && !idx_mapped;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      PIN_OE <= 32'h00000000;
      PIN_SEG_SEL <= 32'h00000000;
      PIN_PULLUP <= 32'h00000000;
      PIN_ANALOG_SEL <= 32'h00000000;
      KEY_INPUT_EN <= 8'h00;
      IRQ_INPUT_EN <= 8'h00;
      THRESHOLD_SEL_A <= pinmux_pkg::THRESHOLD_RESET;
      THRESHOLD_SEL_B <= pinmux_pkg::THRESHOLD_RESET;
      THRESHOLD_SEL_C <= pinmux_pkg::THRESHOLD_RESET;
    end else if (CE) begin
      PIN_OE <= oe_nxt;
      PIN_SEG_SEL <= seg_nxt;
      PIN_PULLUP <= pu_nxt;
      PIN_ANALOG_SEL <= an_nxt;
      KEY_INPUT_EN <= key_nxt;
      IRQ_INPUT_EN <= irq_nxt;
      THRESHOLD_SEL_A <= thr_a_r;
      THRESHOLD_SEL_B <= thr_b_r;
      THRESHOLD_SEL_C <= thr_c_r;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_seg_wins;
    @(posedge CLK) disable iff (RESET)
    (CE && seg_r[0]) |=> (PIN_SEG_SEL[0] && !PIN_OE[0] && !PIN_ANALOG_SEL[0]);
  endproperty
  a_seg_wins: assert property (p_seg_wins) else $error("segment not taking pin");

  property p_dir_out;
    @(posedge CLK) disable iff (RESET)
    (CE && dir_r[20] && !seg_r[20]) |=> (PIN_OE[20] && !KEY_INPUT_EN[4]);
  endproperty
  a_dir_out: assert property (p_dir_out) else $error("output pin not driven");

  property p_pullup;
    @(posedge CLK) disable iff (RESET)
    (CE && dir_r[3]) |=> !PIN_PULLUP[3];
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on output pin");

  property p_an4;
    @(posedge CLK) disable iff (RESET)
    (CE && !dir_r[0] && !seg_r[0] && analog_sel_r == 8'h04) |=> PIN_ANALOG_SEL[0];
  endproperty
  a_an4: assert property (p_an4) else $error("analog 4 not selected");

  property p_an8;
    @(posedge CLK) disable iff (RESET)
    (CE && !dir_r[4] && !seg_r[4] && analog_sel_r == 8'h08) |=> PIN_ANALOG_SEL[4];
  endproperty
  a_an8: assert property (p_an8) else $error("analog 8 not selected");

  property p_an12;
    @(posedge CLK) disable iff (RESET)
    (CE && !dir_r[8] && !seg_r[8] && analog_sel_r == 8'h0C) |=> PIN_ANALOG_SEL[8];
  endproperty
  a_an12: assert property (p_an12) else $error("analog 12 not selected");

  property p_thr_legal;
    @(posedge CLK) disable iff (RESET)
    1'b1 |-> (thr_a_r[1:0] != pinmux_pkg::THR_BAD);
  endproperty
  a_thr_legal: assert property (p_thr_legal) else $error("forbidden threshold");

  property p_thr_a_wr;
    @(posedge CLK) disable iff (RESET)
    (wr_stb && reg_idx == pinmux_pkg::THRESHOLD_SEL_A_IDX && PWDATA[7:0] == 8'h99)
      |=> ##1 (THRESHOLD_SEL_A == 8'h99 || !$past(CE));
  endproperty
  a_thr_a_wr: assert property (p_thr_a_wr) else $error("threshold write lost");

  property p_thr_reset;
    @(posedge CLK) $fell(RESET) |-> (thr_b_r == 8'h00 && thr_c_r == 8'h00);
  endproperty
  a_thr_reset: assert property (p_thr_reset) else $error("threshold reset wrong");

  // a frozen clock enable must not let any pin control move
  property p_ce_hold;
    @(posedge CLK) disable iff (RESET)
    !CE |=> ($stable(PIN_OE) && $stable(PIN_SEG_SEL) && $stable(THRESHOLD_SEL_A));
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("outputs moved with ce low");

  property p_slverr;
    @(posedge CLK) disable iff (RESET)
    (CE && $past(CE) && slverr_c) |-> PSLVERR;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access not flagged");

endmodule // port_function_select_and_threshold

// ==== pad_ring_model.sv ====
// partner: pad ring seen from the package pins of ports 0 to 3
`timescale 1ns/1ps
module pad_ring_model (
  // clock
  input wire logic clk,
  // controls from the pin mux
  input wire logic [31:0] oe,
  input wire logic [31:0] pull_en,
  input wire logic [31:0] seg,
  // resolved pad levels
  output logic [31:0] pad
);
  // port latch data is not modelled: driven pins show a fixed pattern
  localparam logic [31:0] DRIVE_PATTERN = 32'h5A5A5A5A;
  logic [31:0] float_r;
  // an undriven, unpulled pad wanders, so it never keeps a stale value
  always @(posedge clk) begin
    float_r <= ~float_r;
  end
  initial float_r = 32'h0F0F0F0F;
  // segment driver toggles, pull-up only acts on a pin that nobody drives
  assign pad = (oe & DRIVE_PATTERN) | (seg & ~oe & float_r)
             | (~oe & ~seg & pull_en) | (~oe & ~seg & ~pull_en & float_r);
endmodule // pad_ring_model

// ==== port_function_select_and_threshold_tb_top.sv ====
// testbench: register access, pin function and threshold checks
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin n_fail++; \
  $display("MISMATCH %s exp=%h got=%h", nm, ex, gt); end end
module port_function_select_and_threshold_tb_top;
  logic CLK, RESET, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [13:0] PADDR;
  logic [31:0] PWDATA, PRDATA, PIN_OE, PIN_SEG_SEL, PIN_PULLUP, PIN_ANALOG_SEL, pad;
  logic [7:0] KEY_INPUT_EN, IRQ_INPUT_EN, THRESHOLD_SEL_A, THRESHOLD_SEL_B, THRESHOLD_SEL_C;
  logic [31:0] rd, exp_an;
  logic err;
  int n_fail, checks, cyc;
  // ----------------------------------------
  // clock, design and partner
  // ----------------------------------------
  always #2.5 CLK = ~CLK;
  port_function_select_and_threshold DUT (.CLK(CLK), .RESET(RESET), .CE(CE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_OE(PIN_OE), .PIN_SEG_SEL(PIN_SEG_SEL),
    .PIN_PULLUP(PIN_PULLUP), .PIN_ANALOG_SEL(PIN_ANALOG_SEL), .KEY_INPUT_EN(KEY_INPUT_EN),
    .IRQ_INPUT_EN(IRQ_INPUT_EN), .THRESHOLD_SEL_A(THRESHOLD_SEL_A),
    .THRESHOLD_SEL_B(THRESHOLD_SEL_B), .THRESHOLD_SEL_C(THRESHOLD_SEL_C));
  pad_ring_model partner (.clk(CLK), .oe(PIN_OE), .pull_en(PIN_PULLUP), .seg(PIN_SEG_SEL),
    .pad(pad));
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  // one apb transfer; the master waits on pready, never on a fixed count
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= {idx, 2'b00};
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
    @(posedge CLK);
    #1;
  endtask
  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] ex, input string nm);
    apb(1'b0, idx, 32'h00000000);
    `CHK(nm, ex, rd)
  endtask
  task automatic final_report();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // bounded run: the whole sequence needs well under a thousand cycles
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    CLK = 1'b0; RESET = 1'b1; CE = 1'b1; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0;
    PADDR = 14'h0000; PWDATA = 32'h00000000; n_fail = 0; checks = 0; cyc = 0;
    repeat (6) @(posedge CLK);
    RESET <= 1'b0;
    rd_chk(pinmux_pkg::THRESHOLD_SEL_A_IDX, 32'h00000000, "thr_a_reset");
    rd_chk(pinmux_pkg::THRESHOLD_SEL_B_IDX, 32'h00000000, "thr_b_reset");
    rd_chk(pinmux_pkg::THRESHOLD_SEL_C_IDX, 32'h00000000, "thr_c_reset");
    `CHK("thr_pins_reset", 24'h000000, {THRESHOLD_SEL_A, THRESHOLD_SEL_B, THRESHOLD_SEL_C})
    $display("test reset done");
    wr(pinmux_pkg::THRESHOLD_SEL_A_IDX, 32'h00000026);
    `CHK("thr_a_p0", pinmux_pkg::THR_HIGH, THRESHOLD_SEL_A[1:0])
    `CHK("thr_a_p1", pinmux_pkg::THR_LOW, THRESHOLD_SEL_A[3:2])
    `CHK("thr_a_p3", pinmux_pkg::THR_HALF, THRESHOLD_SEL_A[7:6])
    wr(pinmux_pkg::THRESHOLD_SEL_B_IDX, 32'h00000019);
    `CHK("thr_b", 8'h19, THRESHOLD_SEL_B)
    wr(pinmux_pkg::THRESHOLD_SEL_C_IDX, 32'h00000024);
    `CHK("thr_c", 8'h24, THRESHOLD_SEL_C)
    rd_chk(pinmux_pkg::THRESHOLD_SEL_C_IDX, 32'h00000024, "thr_c_rd");
    // forbidden code in field 0 keeps the old code, other fields move
    wr(pinmux_pkg::THRESHOLD_SEL_A_IDX, 32'h0000001B);
    rd_chk(pinmux_pkg::THRESHOLD_SEL_A_IDX, 32'h0000001A, "thr_a_bad");
    wr(pinmux_pkg::THRESHOLD_SEL_A_IDX, 32'h00000099);
    `CHK("thr_a_99", 8'h99, THRESHOLD_SEL_A)
    apb(1'b0, 12'h3FF, 32'h00000000);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_rd", 32'h00000000, rd)
    $display("test threshold done");
    wr(pinmux_pkg::PORT_DIR_IDX, 32'hFFFFFFFF);
    wr(pinmux_pkg::SEG_EN_IDX, 32'hFFFFFFFF);
    `CHK("seg_oe", 32'h00000000, PIN_OE)
    `CHK("seg_sel", 32'hFFFFFFFF, PIN_SEG_SEL)
    wr(pinmux_pkg::SEG_EN_IDX, 32'h00000000);
    `CHK("out_oe", 32'hFFFFFFFF, PIN_OE)
    wr(pinmux_pkg::PORT_DIR_IDX, 32'h0000FFFF);
    wr(pinmux_pkg::SEG_EN_IDX, 32'h00FF0000);
    wr(pinmux_pkg::PULLUP_IDX, 32'hF0F0F0F0);
    `CHK("in_oe", 32'h0000FFFF, PIN_OE)
    `CHK("pullup", 32'hF0000000, PIN_PULLUP)
    `CHK("pad_pulled", 32'hF0000000, pad & 32'hF0000000)
    $display("test direction done");
    wr(pinmux_pkg::PORT_DIR_IDX, 32'h00000000);
    wr(pinmux_pkg::SEG_EN_IDX, 32'h00000000);
    for (int g = 0; g < 4; g++) begin
      for (int c = 0; c < 8; c++) begin
        wr(pinmux_pkg::ANALOG_SEL_IDX, 32'(g * 8 + c));
        exp_an = 32'h00000000;
        if (g == 0 && c >= 4) exp_an[c - 4] = 1'b1;
        if (g == 1) exp_an[c < 4 ? 4 + c : 4 + c] = 1'b1;
        `CHK("analog_sel", exp_an, PIN_ANALOG_SEL)
      end
    end
    wr(pinmux_pkg::ANALOG_SEL_IDX, 32'h00000004);
    wr(pinmux_pkg::SEG_EN_IDX, 32'h00000001);
    `CHK("analog_seg", 32'h00000000, PIN_ANALOG_SEL)
    wr(pinmux_pkg::SEG_EN_IDX, 32'h00000000);
    wr(pinmux_pkg::PORT_DIR_IDX, 32'h00000001);
    `CHK("analog_dir", 32'h00000000, PIN_ANALOG_SEL)
    $display("test analog done");
    wr(pinmux_pkg::PORT_DIR_IDX, 32'h01000000);
    wr(pinmux_pkg::SEG_EN_IDX, 32'h00020000);
    wr(pinmux_pkg::KEY_IRQ_IDX, 32'h3C40FF0F);
    `CHK("key_en", 8'hF0, KEY_INPUT_EN)
    `CHK("irq_en", 8'h3C, IRQ_INPUT_EN)
    wr(pinmux_pkg::KEY_IRQ_IDX, 32'hFF00FF00);
    `CHK("key_en2", 8'hFD, KEY_INPUT_EN)
    `CHK("irq_en2", 8'hFE, IRQ_INPUT_EN)
    wr(pinmux_pkg::STATUS_IDX, 32'hFFFFFFFF);
    rd_chk(pinmux_pkg::STATUS_IDX, 32'h00FEFD00, "status");
    $display("test key irq done");
    // ce low holds the pins at their old state until it returns
    apb(1'b1, pinmux_pkg::PORT_DIR_IDX, 32'h000000FF);
    CE <= 1'b0;
    repeat (3) @(posedge CLK);
    #1;
    `CHK("ce_hold", 32'h01000000, PIN_OE)
    CE <= 1'b1;
    @(posedge CLK);
    #1;
    `CHK("ce_run", 32'h000000FF, PIN_OE)
    // second reset in mid-run clears written thresholds
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    rd_chk(pinmux_pkg::THRESHOLD_SEL_B_IDX, 32'h00000000, "thr_b_rst2");
    `CHK("thr_pins_rst2", 16'h0000, {THRESHOLD_SEL_B, THRESHOLD_SEL_C})
    `CHK("oe_rst2", 32'h00000000, PIN_OE)
    $display("test ce and reset done");
    final_report();
  end
endmodule // port_function_select_and_threshold_tb_top
